// ### core/srw_defines.svh
// Purpose: constants of the system reset and watchdog block
// Assumes: classic Wishbone, 32-bit data, byte addresses
// Notes: status and option registers are 8 bits wide in byte lane 0; program counter and count read back wider
`ifndef SRW_DEFINES_SVH
`define SRW_DEFINES_SVH

`define SRW_ADR_STATUS 8'h00
`define SRW_ADR_OPT1 8'h04
`define SRW_ADR_OPT2 8'h08
`define SRW_ADR_PC_INIT 8'h0C
`define SRW_ADR_COUNT 8'h10

`define SRW_ST_POR 7
`define SRW_ST_PIN 6
`define SRW_ST_WDOG 5
`define SRW_ST_OPCODE 4
`define SRW_ST_ADDRESS 3
`define SRW_ST_VOLTAGE 1

`define SRW_O1_EN 7
`define SRW_O1_TMO 6
`define SRW_O1_PIN 0
`define SRW_O2_CLKS 7

`define SRW_O1_RESET 8'hC0
`define SRW_O2_RESET 8'h00

`define SRW_VEC_HI 16'hFFFE
`define SRW_VEC_LO 16'hFFFF
`define SRW_SP_INIT 16'h00FF

`define SRW_CLK_MHZ 200
`define SRW_HOLD_NS 100
`define SRW_HOLD_CYC (((`SRW_HOLD_NS * `SRW_CLK_MHZ) + 999) / 1000)

// 32 ms and 256 ms at a nominal 1 ms slow tick
`define SRW_LIM_LF_SHORT 19'h00020
`define SRW_LIM_LF_LONG 19'h00100
`define SRW_LIM_BUS_SHORT 19'h02000
`define SRW_LIM_BUS_LONG 19'h40000

`endif

// ### core/srw_pkg.sv
// Purpose: types of the system reset and watchdog block
// Assumes: constants live in srw_defines.svh
// Notes: structs carry grouped control and status bits
package srw_pkg;

    typedef enum logic [2:0] {
        SEQ_RUN,
        SEQ_HOLD,
        SEQ_VEC_HI,
        SEQ_VEC_LO,
        SEQ_LOAD
    } seq_state_type;

    typedef struct packed {
        logic por;
        logic pin;
        logic wdog;
        logic illegal_opcode_reset;
        logic illegal_address_reset;
        logic low_voltage_detect;
        logic dbg;
    } reset_src_type;

    typedef struct packed {
        logic enable;
        logic clk_sel;
        logic timeout_sel;
    } wdog_cfg_type;

endpackage

// ### core/watchdog_counter.sv
// Purpose: watchdog counter with selectable overflow count
// Assumes: tick_i is high in each clk_i cycle that counts, a one-cycle pulse or held high
// Notes: overflow_o pulses once when the limit is reached
`timescale 1ns/1ps
`include "srw_defines.svh"
module watchdog_counter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic tick_i,
    input wire logic hold_i,
    input wire srw_pkg::wdog_cfg_type cfg_i,
    output logic overflow_o,
    output logic [18:0] count_o
);

    function automatic logic [18:0] limit_of(input srw_pkg::wdog_cfg_type c);
        if (c.clk_sel) begin
            limit_of = c.timeout_sel ? `SRW_LIM_BUS_LONG : `SRW_LIM_BUS_SHORT;
        end else begin
            limit_of = c.timeout_sel ? `SRW_LIM_LF_LONG : `SRW_LIM_LF_SHORT;
        end
    endfunction

    logic [18:0] limit;

    assign limit = limit_of(cfg_i);

    // count ticks; clear beats everything, hold freezes the value
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i || !cfg_i.enable) begin
            count_o <= 19'h00000;
        end else if (!hold_i && tick_i) begin
            if (count_o == limit - 19'h00001) begin
                count_o <= 19'h00000;
            end else begin
                count_o <= count_o + 19'h00001;
            end
        end
    end

    // overflow pulse, only while enabled
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i || !cfg_i.enable) begin
            overflow_o <= 1'b0;
        end else begin
            overflow_o <= !hold_i && tick_i && (count_o == limit - 19'h00001);
        end
    end

endmodule

// ### core/system_reset_and_watchdog.sv
// Purpose: system reset control, reset status and watchdog timer
// Assumes: vector memory answers one cycle after vec_rd_o
// Notes: registers sit behind a classic Wishbone slave
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`include "srw_defines.svh"
module system_reset_and_watchdog (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic pin_reset_n_i,
    input wire logic low_voltage_detect_i,
    input wire logic lf_clk_i,
    input wire logic illegal_opcode_i,
    input wire logic illegal_address_i,
    input wire logic debug_force_reset_i,
    input wire logic background_debug_i,
    input wire logic stop_mode_i,
    input wire logic [7:0] vec_data_i,
    output logic [15:0] vec_addr_o,
    output logic vec_rd_o,
    output logic cpu_reset_o,
    output logic cpu_load_o,
    output logic [15:0] pc_init_o,
    output logic [15:0] sp_init_o,
    output logic ccr_int_mask_o,
    output logic periph_disable_o,
    output logic pin_force_input_o,
    output logic pin_pullup_off_o
);

    // widen an 8-bit register to a bus word
    function automatic logic [31:0] word_of(input logic [7:0] v);
        word_of = {24'h000000, v};
    endfunction

    // a status bit set by its source, kept while a held reset accumulates
    function automatic logic keep_bit(input logic hit, input logic busy, input logic old);
        keep_bit = hit || (busy && old);
    endfunction

    // synchronisers for inputs that come from outside the clock
    logic pin_n_s1_r;
    logic pin_n_s2_r;
    logic volt_s1_r;
    logic volt_s2_r;
    logic lf_s1_r;
    logic lf_s2_r;
    logic lf_s3_r;

    // register file
    logic [7:0] status_r;
    logic [7:0] opt1_r;
    logic [7:0] opt2_r;
    logic opt1_locked_r;
    logic opt2_locked_r;

    // bus decode
    logic bus_req;
    logic wr_take;
    logic wr_status;
    logic wr_opt1;
    logic wr_opt2;
    logic service;

    // reset sequencing
    srw_pkg::seq_state_type state_r;
    logic [7:0] hold_cnt_r;
    logic [7:0] pc_hi_r;
    srw_pkg::reset_src_type src;
    logic reset_req;
    logic sys_rst;
    logic hold_done;
    logic seq_busy;

    // watchdog
    srw_pkg::wdog_cfg_type wcfg;
    logic lf_tick;
    logic wd_tick;
    logic wd_hold;
    logic wd_clear;
    logic wd_overflow;
    logic [18:0] wd_count;

    // two flip-flops before any use of pin, low voltage and slow clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_n_s1_r <= 1'b1;
            pin_n_s2_r <= 1'b1;
            volt_s1_r <= 1'b0;
            volt_s2_r <= 1'b0;
        end else begin
            pin_n_s1_r <= pin_reset_n_i;
            pin_n_s2_r <= pin_n_s1_r;
            volt_s1_r <= low_voltage_detect_i;
            volt_s2_r <= volt_s1_r;
        end
    end

    // slow clock edge found on the synchronised copy only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lf_s1_r <= 1'b0;
            lf_s2_r <= 1'b0;
            lf_s3_r <= 1'b0;
        end else begin
            lf_s1_r <= lf_clk_i;
            lf_s2_r <= lf_s1_r;
            lf_s3_r <= lf_s2_r;
        end
    end

    assign lf_tick = lf_s2_r && !lf_s3_r;

    // collect the reset sources of this cycle
    always_comb begin
        src.por = 1'b0;
        src.pin = !pin_n_s2_r && opt1_r[`SRW_O1_PIN];
        src.wdog = wd_overflow;
        src.illegal_opcode_reset = illegal_opcode_i;
        src.illegal_address_reset = illegal_address_i;
        src.low_voltage_detect = volt_s2_r;
        src.dbg = debug_force_reset_i;
    end

    assign reset_req = |src;

    // the system sits in reset from the request until the vector loads
    assign sys_rst = rst_i || (state_r != srw_pkg::SEQ_RUN);

    // last hold cycle; the sequencer and the vector port must agree on it
    assign hold_done = (hold_cnt_r == 8'(`SRW_HOLD_CYC - 1));
    // any state but run means the sequence still owns the system
    assign seq_busy = (state_r != srw_pkg::SEQ_RUN);

    // reset sequencer: hold, then fetch the two vector bytes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= srw_pkg::SEQ_HOLD;
            hold_cnt_r <= 8'h00;
        end else begin
            unique case (state_r)
                srw_pkg::SEQ_RUN: begin
                    if (reset_req) begin
                        state_r <= srw_pkg::SEQ_HOLD;
                        hold_cnt_r <= 8'h00;
                    end
                end
                srw_pkg::SEQ_HOLD: begin
                    // a source still asserted keeps the hold going
                    if (reset_req) begin
                        hold_cnt_r <= 8'h00;
                    end else if (hold_done) begin
                        state_r <= srw_pkg::SEQ_VEC_HI;
                    end else begin
                        hold_cnt_r <= hold_cnt_r + 8'h01;
                    end
                end
                srw_pkg::SEQ_VEC_HI: begin
                    state_r <= srw_pkg::SEQ_VEC_LO;
                end
                srw_pkg::SEQ_VEC_LO: begin
                    state_r <= srw_pkg::SEQ_LOAD;
                end
                srw_pkg::SEQ_LOAD: begin
                    state_r <= srw_pkg::SEQ_RUN;
                end
                // unused codes fall back into hold, with hold_cnt_r not cleared, rather than lock up
                default: begin
                    state_r <= srw_pkg::SEQ_HOLD;
                end
            endcase
        end
    end

    // vector read port; high byte first at the lower address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vec_addr_o <= `SRW_VEC_HI;
            vec_rd_o <= 1'b0;
        end else if (state_r == srw_pkg::SEQ_HOLD && !reset_req && hold_done) begin
            vec_addr_o <= `SRW_VEC_HI;
            vec_rd_o <= 1'b1;
        end else if (state_r == srw_pkg::SEQ_VEC_HI) begin
            vec_addr_o <= `SRW_VEC_LO;
            vec_rd_o <= 1'b1;
        end else begin
            vec_rd_o <= 1'b0;
        end
    end

    // capture vector bytes one cycle after each read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_hi_r <= 8'h00;
            pc_init_o <= 16'h0000;
        end else if (state_r == srw_pkg::SEQ_VEC_LO) begin
            pc_hi_r <= vec_data_i;
        end else if (state_r == srw_pkg::SEQ_LOAD) begin
            pc_init_o <= {pc_hi_r, vec_data_i};
        end
    end

    // cpu start state, loaded with the pulse at the end of reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_load_o <= 1'b0;
            sp_init_o <= `SRW_SP_INIT;
            ccr_int_mask_o <= 1'b1;
        end else begin
            cpu_load_o <= (state_r == srw_pkg::SEQ_LOAD);
            sp_init_o <= `SRW_SP_INIT;
            ccr_int_mask_o <= 1'b1;
        end
    end

    // cpu, peripherals and pins are held while any reset is active
    // cpu_reset_o drops with the load pulse; pins and peripherals stay held one cycle longer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_reset_o <= 1'b1;
            periph_disable_o <= 1'b1;
            pin_force_input_o <= 1'b1;
            pin_pullup_off_o <= 1'b1;
        end else begin
            cpu_reset_o <= reset_req || (state_r != srw_pkg::SEQ_RUN &&
                                         state_r != srw_pkg::SEQ_LOAD);
            periph_disable_o <= reset_req || seq_busy;
            pin_force_input_o <= reset_req || seq_busy;
            pin_pullup_off_o <= reset_req || seq_busy;
        end
    end

    // status: power-on alone at rst_i, new sources replace old ones
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_r <= 8'h00;
            status_r[`SRW_ST_POR] <= 1'b1;
        end else if (reset_req) begin
            // a fresh request clears bits left from the previous reset
            if (!seq_busy) begin
                status_r <= 8'h00;
            end
            status_r[`SRW_ST_PIN] <= keep_bit(src.pin, seq_busy, status_r[`SRW_ST_PIN]);
            status_r[`SRW_ST_WDOG] <= keep_bit(src.wdog, seq_busy, status_r[`SRW_ST_WDOG]);
            status_r[`SRW_ST_OPCODE] <= keep_bit(src.illegal_opcode_reset, seq_busy, status_r[`SRW_ST_OPCODE]);
            status_r[`SRW_ST_ADDRESS] <= keep_bit(src.illegal_address_reset, seq_busy, status_r[`SRW_ST_ADDRESS]);
            status_r[`SRW_ST_VOLTAGE] <= keep_bit(src.low_voltage_detect, seq_busy, status_r[`SRW_ST_VOLTAGE]);
            status_r[`SRW_ST_POR] <= keep_bit(1'b0, seq_busy, status_r[`SRW_ST_POR]);
        end
    end

    // bus decode; effects land on the edge that raises ack
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_take = bus_req && wb_we_i;
    assign wr_status = wr_take && (wb_adr_i == `SRW_ADR_STATUS);
    assign wr_opt1 = wr_take && wb_sel_i[0] && (wb_adr_i == `SRW_ADR_OPT1) && !opt1_locked_r;
    assign wr_opt2 = wr_take && wb_sel_i[0] && (wb_adr_i == `SRW_ADR_OPT2) && !opt2_locked_r;

    // any write to the status address services; lane select not needed
    assign service = wr_status || wr_opt1 || wr_opt2;

    // write-once option registers, unlocked again by every reset
    always_ff @(posedge clk_i) begin
        if (sys_rst) begin
            opt1_r <= `SRW_O1_RESET;
            opt1_locked_r <= 1'b0;
        end else if (wr_opt1) begin
            opt1_r <= wb_dat_i[7:0];
            opt1_locked_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst) begin
            opt2_r <= `SRW_O2_RESET;
            opt2_locked_r <= 1'b0;
        end else if (wr_opt2) begin
            opt2_r <= wb_dat_i[7:0];
            opt2_locked_r <= 1'b1;
        end
    end

    // one wait state: ack rises the cycle after the request, then drops
    // ack itself masks the request, so a strobe still held in the ack cycle is not taken twice; one held longer is taken again
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // read mux; unmapped addresses answer zero
    // reads have no side effect, so polling the count never services the watchdog
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (bus_req && !wb_we_i) begin
            unique case (wb_adr_i)
                `SRW_ADR_STATUS: wb_dat_o <= word_of(status_r);
                `SRW_ADR_OPT1: wb_dat_o <= word_of(opt1_r);
                `SRW_ADR_OPT2: wb_dat_o <= word_of(opt2_r);
                `SRW_ADR_PC_INIT: wb_dat_o <= {16'h0000, pc_init_o};
                `SRW_ADR_COUNT: wb_dat_o <= {13'h0000, wd_count};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // watchdog control from the option registers
    always_comb begin
        wcfg.enable = opt1_r[`SRW_O1_EN];
        wcfg.timeout_sel = opt1_r[`SRW_O1_TMO];
        wcfg.clk_sel = opt2_r[`SRW_O2_CLKS];
    end

    // bus clock counts every cycle, else the slow tick
    assign wd_tick = wcfg.clk_sel ? 1'b1 : lf_tick;
    // hold in debug, and in stop when on the bus clock
    assign wd_hold = background_debug_i || (stop_mode_i && wcfg.clk_sel);
    // slow clock restarts from zero across stop
    assign wd_clear = service || (stop_mode_i && !wcfg.clk_sel);

    // the counter sits in reset with the rest of the system, so every reset restarts it
    watchdog_counter u_wdog (
        .clk_i(clk_i),
        .rst_i(sys_rst),
        .clear_i(wd_clear),
        .tick_i(wd_tick),
        .hold_i(wd_hold),
        .cfg_i(wcfg),
        .overflow_o(wd_overflow),
        .count_o(wd_count)
    );

endmodule

// ### dv/srw_vec_model.sv
// Purpose: vector memory model feeding the reset fetch
// Assumes: data is taken the cycle after a one-cycle read strobe
// Notes: between reads the data lines toggle so stale bytes never look valid
`timescale 1ns/1ps
module srw_vec_model #(
    parameter logic [15:0] VEC = 16'hC35A
) (
    input wire logic clk_i,
    input wire logic rd_i,
    input wire logic [15:0] addr_i,
    output logic [7:0] data_o
);
    initial data_o = 8'hA5;
    // high byte sits at the lower vector address
    always @(posedge clk_i) begin
        if (rd_i) begin
            data_o <= (addr_i == 16'hFFFE) ? VEC[15:8] : (addr_i == 16'hFFFF) ? VEC[7:0] : 8'hEE;
        end else begin
            data_o <= ~data_o;
        end
    end
endmodule

// ### dv/srw_asserts.sv
// Purpose: port-level checks of reset sequencing and bus answers
// Assumes: single clock, synchronous active-high reset
// Notes: bound to the block below the module
`timescale 1ns/1ps
module srw_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic low_voltage_detect_i,
    input wire logic illegal_opcode_i,
    input wire logic illegal_address_i,
    input wire logic debug_force_reset_i,
    input wire logic [7:0] vec_data_i,
    input wire logic [15:0] vec_addr_o,
    input wire logic vec_rd_o,
    input wire logic cpu_reset_o,
    input wire logic cpu_load_o,
    input wire logic [15:0] pc_init_o,
    input wire logic [15:0] sp_init_o,
    input wire logic ccr_int_mask_o,
    input wire logic periph_disable_o,
    input wire logic pin_force_input_o,
    input wire logic pin_pullup_off_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // the sources, other than pin and watchdog, that must pull the system into reset
    logic src_seen;
    assign src_seen = low_voltage_detect_i || illegal_opcode_i || illegal_address_i || debug_force_reset_i;

    // two back-to-back vector reads
    sequence seq_fetch;
        vec_rd_o && vec_addr_o == 16'hFFFE ##1 vec_rd_o && vec_addr_o == 16'hFFFF;
    endsequence

    AST_VEC_ORDER: assert property (vec_rd_o && vec_addr_o == 16'hFFFE |=> vec_rd_o && vec_addr_o == 16'hFFFF)
        else $error("vector reads out of order");
    AST_LOAD: assert property (seq_fetch |-> ##2 (cpu_load_o && !cpu_reset_o))
        else $error("load pulse missing after fetch");
    AST_PC: assert property (seq_fetch ##2 cpu_load_o |-> pc_init_o == {$past(vec_data_i, 2), $past(vec_data_i)})
        else $error("program counter not built high byte first");
    AST_RELEASE: assert property ($fell(cpu_reset_o) |-> cpu_load_o)
        else $error("reset released without load");
    AST_SP: assert property (cpu_load_o |-> sp_init_o == 16'h00FF)
        else $error("stack pointer init wrong");
    AST_MASK: assert property (cpu_load_o |-> ccr_int_mask_o)
        else $error("interrupt mask not set at load");
    AST_PINS: assert property (cpu_reset_o |-> periph_disable_o && pin_force_input_o && pin_pullup_off_o)
        else $error("pins or peripherals active in reset");
    AST_SRC: assert property (src_seen && !cpu_reset_o |-> ##[1:6] cpu_reset_o)
        else $error("reset source ignored");
    AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
endmodule

bind system_reset_and_watchdog srw_asserts u_chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o),
    .low_voltage_detect_i(low_voltage_detect_i),
    .illegal_opcode_i(illegal_opcode_i),
    .illegal_address_i(illegal_address_i),
    .debug_force_reset_i(debug_force_reset_i),
    .vec_data_i(vec_data_i),
    .vec_addr_o(vec_addr_o),
    .vec_rd_o(vec_rd_o),
    .cpu_reset_o(cpu_reset_o),
    .cpu_load_o(cpu_load_o),
    .pc_init_o(pc_init_o),
    .sp_init_o(sp_init_o),
    .ccr_int_mask_o(ccr_int_mask_o),
    .periph_disable_o(periph_disable_o),
    .pin_force_input_o(pin_force_input_o),
    .pin_pullup_off_o(pin_pullup_off_o)
);

// ### dv/tb.sv
// Purpose: self-checking bench for the reset and watchdog block
// Assumes: classic Wishbone single cycles, slow tick every 20 clocks
// Notes: slow clock sped up so the 256-tick count fits the run
`timescale 1ns/1ps
`include "srw_defines.svh"
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] rdat;
    logic ack;
    logic pin_n = 1'b1;
    logic lf = 1'b0;
    logic bdm = 1'b0;
    logic stop = 1'b0;
    logic [3:0] src = 4'h0;
    logic [7:0] vdat;
    logic [15:0] vadr;
    logic vrd;
    logic cpu_reset;
    logic cpu_load;
    logic [15:0] pc;
    logic [15:0] sp;
    logic mask;
    logic [4:0] lf_cnt = 5'h00;
    logic [18:0] a;
    logic [18:0] b;
    logic [7:0] exp_st [4] = '{8'h10, 8'h08, 8'h02, 8'h00};
    int error_cnt = 0;
    int n_tests = 0;
    int n;

    always #2.5 clk_i = ~clk_i;
    // slow tick source, one rise every 20 bus cycles
    always @(posedge clk_i) begin
        lf_cnt <= (lf_cnt == 5'h13) ? 5'h00 : lf_cnt + 5'h01;
        lf <= (lf_cnt < 5'h0A);
    end

    system_reset_and_watchdog u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pin_reset_n_i(pin_n), .low_voltage_detect_i(src[2]), .lf_clk_i(lf), .illegal_opcode_i(src[0]),
        .illegal_address_i(src[1]), .debug_force_reset_i(src[3]), .background_debug_i(bdm),
        .stop_mode_i(stop), .vec_data_i(vdat), .vec_addr_o(vadr), .vec_rd_o(vrd), .cpu_reset_o(cpu_reset),
        .cpu_load_o(cpu_load), .pc_init_o(pc), .sp_init_o(sp), .ccr_int_mask_o(mask),
        .periph_disable_o(), .pin_force_input_o(), .pin_pullup_off_o());
    srw_vec_model u_vec (.clk_i(clk_i), .rd_i(vrd), .addr_i(vadr), .data_o(vdat));

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [18:0] got, input logic [18:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic inr(input int v, input int lo, input int hi);
        n_tests++;
        if (v < lo || v > hi) begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h..%h", $time, v, lo, hi);
        end
    endtask

    // one classic cycle, held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] d, output logic [18:0] q);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        wdat <= {24'h000000, d};
        sel <= 4'hF;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 40);
        q = rdat[18:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, ack, 1'b1);
            close_out();
        end
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] ad, input logic [18:0] exp);
        logic [18:0] q;
        bus(1'b0, ad, 8'h00, q);
        chk(q, exp);
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        logic [18:0] q;
        bus(1'b1, ad, d, q);
    endtask

    // bounded wait for the load pulse or for reset to assert
    task automatic wait_ev(input bit on_load, input int lim, output int k);
        k = 0;
        while ((on_load ? cpu_load : cpu_reset) !== 1'b1) begin
            @(posedge clk_i);
            k++;
            if (k > lim) begin
                error_cnt++;
                $display("mismatch at %0t got %h exp %h", $time, k, lim);
                close_out();
            end
        end
    endtask

    task automatic boot();
        int k;
        wait_ev(1'b1, 80, k);
        chk({3'b000, pc}, 19'h0C35A);
        chk({3'b000, sp}, {3'b000, `SRW_SP_INIT});
        chk({18'h0, mask}, 19'h1);
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        boot();
        rd(`SRW_ADR_STATUS, 19'h80);
        rd(`SRW_ADR_OPT1, 19'hC0);
        rd(`SRW_ADR_OPT2, 19'h00);
        rd(8'h1C, 19'h0);
        $display("test defaults done");
        // bus clock, short count, then lock and hold checks
        wr(`SRW_ADR_OPT2, 8'h80);
        wr(`SRW_ADR_OPT1, 8'h80);
        wr(`SRW_ADR_OPT1, 8'hC1);
        rd(`SRW_ADR_OPT1, 19'h80);
        rd(`SRW_ADR_OPT2, 19'h80);
        wr(`SRW_ADR_STATUS, 8'hFF);
        bus(1'b0, `SRW_ADR_COUNT, 8'h00, a);
        chk({18'h0, a < 19'h8}, 19'h1);
        rd(`SRW_ADR_STATUS, 19'h80);
        bus(1'b0, `SRW_ADR_COUNT, 8'h00, a);
        bus(1'b0, `SRW_ADR_COUNT, 8'h00, b);
        chk(b - a, 19'h3);
        bdm <= 1'b1;
        bus(1'b0, `SRW_ADR_COUNT, 8'h00, a);
        bus(1'b0, `SRW_ADR_COUNT, 8'h00, b);
        chk(b - a, 19'h0);
        bdm <= 1'b0;
        stop <= 1'b1;
        bus(1'b0, `SRW_ADR_COUNT, 8'h00, a);
        bus(1'b0, `SRW_ADR_COUNT, 8'h00, b);
        chk(b - a, 19'h0);
        stop <= 1'b0;
        bus(1'b0, `SRW_ADR_COUNT, 8'h00, b);
        chk({18'h0, (b - a) < 19'h8}, 19'h1);
        $display("test hold done");
        wr(`SRW_ADR_STATUS, 8'h00);
        wait_ev(1'b0, 8300, n);
        inr(n, 8188, 8198);
        boot();
        rd(`SRW_ADR_STATUS, 19'h20);
        rd(`SRW_ADR_OPT1, 19'hC0);
        $display("test bus overflow done");
        // slow clock: stop clears, then short count
        repeat (60) @(posedge clk_i);
        bus(1'b0, `SRW_ADR_COUNT, 8'h00, a);
        chk({18'h0, a != 19'h0}, 19'h1);
        stop <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(`SRW_ADR_COUNT, 19'h0);
        stop <= 1'b0;
        wr(`SRW_ADR_OPT1, 8'h80);
        wr(`SRW_ADR_OPT2, 8'h00);
        wait_ev(1'b0, 800, n);
        inr(n, 600, 700);
        boot();
        rd(`SRW_ADR_STATUS, 19'h20);
        wait_ev(1'b0, 5400, n);
        inr(n, 5000, 5200);
        boot();
        $display("test slow clock done");
        for (int i = 0; i < 4; i++) begin
            src <= 4'h1 << i;
            repeat (2) @(posedge clk_i);
            src <= 4'h0;
            wait_ev(1'b0, 10, n);
            boot();
            rd(`SRW_ADR_STATUS, {11'h0, exp_st[i]});
        end
        $display("test sources done");
        pin_n <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk({18'h0, cpu_reset}, 19'h0);
        pin_n <= 1'b1;
        // let the synchronised pin go high before enabling it as a source
        repeat (4) @(posedge clk_i);
        wr(`SRW_ADR_OPT1, 8'h01);
        repeat (40) @(posedge clk_i);
        rd(`SRW_ADR_COUNT, 19'h0);
        pin_n <= 1'b0;
        wait_ev(1'b0, 10, n);
        pin_n <= 1'b1;
        boot();
        rd(`SRW_ADR_STATUS, 19'h40);
        $display("test pin done");
        close_out();
    end
endmodule
